// File: hw/ssd_pkg.sv
package ssd_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STAT_OFFS = 8'h04;
  localparam logic [7:0] DATA_OFFS = 8'h08;

  // Control register fields
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_MSTR_BIT = 4;
  localparam int CTRL_TXIE_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [7:0] CTRL_WR_MASK = 8'h32;

  // Status and rate control fields
  localparam int STAT_RXF_BIT = 7;
  localparam int STAT_OVR_BIT = 6;
  localparam int STAT_MODE_FAULT_FLAG_BIT = 4;
  localparam int STAT_TXE_BIT = 3;
  localparam int STAT_FDEN_BIT = 2;
  localparam int STAT_RATE_HI = 1;
  localparam int STAT_RATE_LO = 0;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // Rate select codes and divisors
  localparam int BD_W = 8;
  localparam logic [1:0] RATE_DIV2 = 2'h0;
  localparam logic [1:0] RATE_DIV8 = 2'h1;
  localparam logic [1:0] RATE_DIV32 = 2'h2;
  localparam logic [BD_W-1:0] BD_2 = 8'h02;
  localparam logic [BD_W-1:0] BD_8 = 8'h08;
  localparam logic [BD_W-1:0] BD_32 = 8'h20;
  localparam logic [BD_W-1:0] BD_128 = 8'h80;
  localparam logic [BD_W-1:0] BD_ONE = 8'h01;

  // Shifter
  localparam int BYTE_MSB = 7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Pin synchroniser lanes; select idles high
  localparam int SYNC_W = 4;
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h8;

  typedef enum {ENG_IDLE, ENG_READY, ENG_SHIFT} ssd_eng_type;

  function automatic logic [BD_W-1:0] ssd_bd(input logic [1:0] sel);
    if (sel == RATE_DIV2) begin
      return BD_2;
    end else if (sel == RATE_DIV8) begin
      return BD_8;
    end else if (sel == RATE_DIV32) begin
      return BD_32;
    end
    return BD_128;
  endfunction

endpackage

// File: hw/ssd_sync.sv
`timescale 1ns/1ps
module ssd_sync
  import ssd_pkg::*;
#(
  parameter int W = SYNC_W,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule

// File: hw/ssd_rate_div.sv
`timescale 1ns/1ps
module ssd_rate_div
  import ssd_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [1:0] rateSel,
  output logic tick
);

  logic [BD_W-1:0] cnt_reg;
  logic [BD_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // One tick per half serial period: base clock over twice the divisor
  always_comb begin
    cnt_next = BD_W'(cnt_reg + BD_ONE);
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == BD_W'(ssd_bd(rateSel) - BD_ONE)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  property p_div2Rate;
    @(posedge mclk) disable iff (!nrst)
    (tick_reg && run && rateSel == RATE_DIV2) ##1 run |=> tick_reg;
  endproperty
  a_div2Rate: assert property (p_div2Rate) else $error("div2 tick late");

  property p_tickSpacing;
    @(posedge mclk) disable iff (!nrst)
    tick_reg |=> !tick_reg;
  endproperty
  a_tickSpacing: assert property (p_tickSpacing) else $error("tick too close");

endmodule

// File: hw/ssd_spi_core.sv
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ssd_spi_core
  import ssd_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [7:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire logic sclkI,
  output logic sclkO,
  output logic sclkOe,
  input wire logic mosiI,
  output logic mosiO,
  output logic mosiOe,
  input wire logic misoI,
  output logic misoO,
  output logic misoOe,
  input wire logic selectN,
  output logic txIrq,
  output logic ssGpioMode
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
    return a == offs;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock divider

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  logic sclkS, mosiS, misoS, ssS;
  logic tick;

  assign pinRaw = {selectN, misoI, mosiI, sclkI};

  ssd_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) uSync (
    .mclk(mclk),
    .nrst(nrst),
    .din(pinRaw),
    .dout(pinSync)
  );

  assign sclkS = pinSync[PIN_SCLK];
  assign mosiS = pinSync[PIN_MOSI];
  assign misoS = pinSync[PIN_MISO];
  assign ssS = pinSync[PIN_SS];

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] ctrl_reg, ctrl_next;
  logic faultEn_reg, faultEn_next;
  logic [1:0] rateSel_reg, rateSel_next;
  logic txFull_reg, txFull_next;
  logic [7:0] txBuf_reg, txBuf_next;
  logic rxFull_reg, rxFull_next;
  logic [7:0] rxBuf_reg, rxBuf_next;
  logic ovr_reg, ovr_next;
  logic ovrArm_reg, ovrArm_next;
  logic mode_fault_flag_reg, mode_fault_flag_next;
  logic modfArm_reg, modfArm_next;
  logic wbAck_reg, wbAck_next;
  logic [31:0] wbDat_reg, wbDat_next;
  logic txIrq_reg, txIrq_next;
  logic ssGpio_reg, ssGpio_next;

  ssd_eng_type state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic sclkO_reg, sclkO_next;
  logic mosiO_reg, mosiO_next;
  logic misoO_reg, misoO_next;
  logic sclkOe_reg, mosiOe_reg, misoOe_reg;
  logic rxDone_reg, rxDone_next;
  logic sclkPrev_reg, ssPrev_reg;

  logic enable, master, txIe;
  logic busReq, busDone, issue;
  logic ctrlWr, statWr, dataWr, dataRd, statRd;
  logic ssFall, ssRise, sclkRise, sclkFall;
  logic take, faultEvt;
  logic [7:0] statusByte;
  logic [31:0] rdMux;

  assign enable = ctrl_reg[CTRL_EN_BIT];
  assign master = ctrl_reg[CTRL_MSTR_BIT];
  assign txIe = ctrl_reg[CTRL_TXIE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: ack one cycle after request, write lands on the ack edge

  assign busReq = wbCycI && wbStbI;
  assign issue = busReq && !wbAck_reg;
  assign busDone = busReq && wbAck_reg;
  assign ctrlWr = busDone && wbWeI && wbSelI[0] && hit(wbAdrI, CTRL_OFFS);
  assign statWr = busDone && wbWeI && wbSelI[0] && hit(wbAdrI, STAT_OFFS);
  assign dataWr = busDone && wbWeI && wbSelI[0] && hit(wbAdrI, DATA_OFFS);
  assign dataRd = busDone && !wbWeI && hit(wbAdrI, DATA_OFFS);
  assign statRd = busDone && !wbWeI && hit(wbAdrI, STAT_OFFS);

  always_comb begin
    statusByte = '0;
    statusByte[STAT_RXF_BIT] = rxFull_reg;
    statusByte[STAT_OVR_BIT] = ovr_reg;
    statusByte[STAT_MODE_FAULT_FLAG_BIT] = mode_fault_flag_reg;
    statusByte[STAT_TXE_BIT] = !txFull_reg;
    statusByte[STAT_FDEN_BIT] = faultEn_reg;
    statusByte[STAT_RATE_HI] = rateSel_reg[1];
    statusByte[STAT_RATE_LO] = rateSel_reg[0];
  end

  always_comb begin
    if (hit(wbAdrI, CTRL_OFFS)) begin
      rdMux = 32'(ctrl_reg);
    end else if (hit(wbAdrI, STAT_OFFS)) begin
      rdMux = 32'(statusByte);
    end else if (hit(wbAdrI, DATA_OFFS)) begin
      rdMux = 32'(rxBuf_reg);
    end else begin
      rdMux = '0;
    end
  end

  always_comb begin
    wbAck_next = issue;
    wbDat_next = issue ? rdMux : wbDat_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins

  assign ssFall = ssPrev_reg && !ssS;
  assign ssRise = !ssPrev_reg && ssS;
  assign sclkRise = !sclkPrev_reg && sclkS;
  assign sclkFall = sclkPrev_reg && !sclkS;

  // Slave takes a byte only while idle, never mid-transfer
  assign take = enable && txFull_reg && state_reg == ENG_IDLE
    && (master || !ssFall);

  // Master without fault detect never looks at select
  assign faultEvt = enable && faultEn_reg
    && (master ? !ssS : (ssRise && state_reg == ENG_SHIFT));

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags; a hardware set wins over a software clear

  always_comb begin
    ctrl_next = ctrl_reg;
    faultEn_next = faultEn_reg;
    rateSel_next = rateSel_reg;
    if (ctrlWr) begin
      ctrl_next = (ctrl_reg & ~CTRL_WR_MASK) | (wbDatI[7:0] & CTRL_WR_MASK);
    end
    if (statWr) begin
      faultEn_next = wbDatI[STAT_FDEN_BIT];
      rateSel_next = {wbDatI[STAT_RATE_HI], wbDatI[STAT_RATE_LO]};
    end
    txFull_next = (txFull_reg && !take) || dataWr;
    txBuf_next = dataWr ? wbDatI[7:0] : txBuf_reg;
    rxFull_next = rxFull_reg;
    rxBuf_next = rxBuf_reg;
    if (dataRd) begin
      rxFull_next = 1'b0;
    end
    if (rxDone_reg && !rxFull_reg) begin
      rxFull_next = 1'b1;
      rxBuf_next = shift_reg;
    end
    ovr_next = ovr_reg;
    ovrArm_next = ovrArm_reg || (statRd && ovr_reg);
    if (dataRd && ovrArm_reg) begin
      ovr_next = 1'b0;
      ovrArm_next = 1'b0;
    end
    if (rxDone_reg && rxFull_reg) begin
      ovr_next = 1'b1;
    end
    mode_fault_flag_next = mode_fault_flag_reg;
    modfArm_next = modfArm_reg || (statRd && mode_fault_flag_reg);
    if (dataWr && modfArm_reg) begin
      mode_fault_flag_next = 1'b0;
      modfArm_next = 1'b0;
    end
    if (faultEvt) begin
      mode_fault_flag_next = 1'b1;
    end
    txIrq_next = txIe && !txFull_next;
    ssGpio_next = !enable || (master && !faultEn_reg);
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine, mode 0: sample on rising, change data on falling

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    sclkO_next = sclkO_reg;
    mosiO_next = mosiO_reg;
    misoO_next = misoO_reg;
    rxDone_next = 1'b0;
    if (!enable) begin
      state_next = ENG_IDLE;
      bitCnt_next = '0;
      sclkO_next = 1'b0;
    end else begin
      case (state_reg)
        ENG_IDLE: begin
          if (!master && ssFall) begin
            state_next = ENG_SHIFT;
            bitCnt_next = '0;
          end else if (take) begin
            shift_next = txBuf_reg;
            bitCnt_next = '0;
            if (master) begin
              mosiO_next = txBuf_reg[BYTE_MSB];
              state_next = ENG_SHIFT;
            end else begin
              misoO_next = txBuf_reg[BYTE_MSB];
              state_next = ENG_READY;
            end
          end
        end
        ENG_READY: begin
          if (master) begin
            state_next = ENG_IDLE;
          end else if (ssFall) begin
            state_next = ENG_SHIFT;
            bitCnt_next = '0;
          end
        end
        ENG_SHIFT: begin
          if (master) begin
            if (tick) begin
              if (!sclkO_reg) begin
                sclkO_next = 1'b1;
                bitCnt_next = 4'(bitCnt_reg + CNT_ONE);
              end else begin
                // Sync lag: pin level from the rising edge is seen only now
                sclkO_next = 1'b0;
                shift_next = {shift_reg[BYTE_MSB-1:0], misoS};
                mosiO_next = shift_reg[BYTE_MSB-1];
                if (bitCnt_reg == BIT_COUNT) begin
                  rxDone_next = 1'b1;
                  state_next = ENG_IDLE;
                end
              end
            end
          end else if (ssRise) begin
            // Deselected slave drops the byte and ignores further clocks
            state_next = ENG_IDLE;
          end else if (sclkRise) begin
            shift_next = {shift_reg[BYTE_MSB-1:0], mosiS};
            bitCnt_next = 4'(bitCnt_reg + CNT_ONE);
            if (bitCnt_reg == BIT_LAST) begin
              rxDone_next = 1'b1;
              state_next = ENG_IDLE;
            end
          end else if (sclkFall) begin
            misoO_next = shift_reg[BYTE_MSB];
          end
        end
        default: state_next = ENG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
      faultEn_reg <= 1'b0;
      rateSel_reg <= RATE_RESET;
      txFull_reg <= 1'b0;
      txBuf_reg <= '0;
      rxFull_reg <= 1'b0;
      rxBuf_reg <= '0;
      ovr_reg <= 1'b0;
      ovrArm_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      modfArm_reg <= 1'b0;
      wbAck_reg <= 1'b0;
      wbDat_reg <= '0;
      txIrq_reg <= 1'b0;
      ssGpio_reg <= 1'b1;
      state_reg <= ENG_IDLE;
      shift_reg <= '0;
      bitCnt_reg <= '0;
      sclkO_reg <= 1'b0;
      mosiO_reg <= 1'b0;
      misoO_reg <= 1'b0;
      sclkOe_reg <= 1'b0;
      mosiOe_reg <= 1'b0;
      misoOe_reg <= 1'b0;
      rxDone_reg <= 1'b0;
      sclkPrev_reg <= 1'b0;
      ssPrev_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      faultEn_reg <= faultEn_next;
      rateSel_reg <= rateSel_next;
      txFull_reg <= txFull_next;
      txBuf_reg <= txBuf_next;
      rxFull_reg <= rxFull_next;
      rxBuf_reg <= rxBuf_next;
      ovr_reg <= ovr_next;
      ovrArm_reg <= ovrArm_next;
      mode_fault_flag_reg <= mode_fault_flag_next;
      modfArm_reg <= modfArm_next;
      wbAck_reg <= wbAck_next;
      wbDat_reg <= wbDat_next;
      txIrq_reg <= txIrq_next;
      ssGpio_reg <= ssGpio_next;
      state_reg <= state_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      sclkO_reg <= sclkO_next;
      mosiO_reg <= mosiO_next;
      misoO_reg <= misoO_next;
      sclkOe_reg <= enable && master;
      mosiOe_reg <= enable && master;
      misoOe_reg <= enable && !master && !ssS;
      rxDone_reg <= rxDone_next;
      sclkPrev_reg <= sclkS;
      ssPrev_reg <= ssS;
    end
  end

  // Divider runs only for an active master, so rate select is moot in slave
  ssd_rate_div uDiv (
    .mclk(mclk),
    .nrst(nrst),
    .run(enable && master && state_reg == ENG_SHIFT),
    .rateSel(rateSel_reg),
    .tick(tick)
  );

  assign wbDatO = wbDat_reg;
  assign wbAckO = wbAck_reg;
  assign sclkO = sclkO_reg;
  assign sclkOe = sclkOe_reg;
  assign mosiO = mosiO_reg;
  assign mosiOe = mosiOe_reg;
  assign misoO = misoO_reg;
  assign misoOe = misoOe_reg;
  assign txIrq = txIrq_reg;
  assign ssGpioMode = ssGpio_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_wrClearsEmpty;
    @(posedge mclk) disable iff (!nrst) dataWr |=> txFull_reg;
  endproperty
  a_wrClearsEmpty: assert property (p_wrClearsEmpty) else $error("write kept empty");

  property p_takeSetsEmpty;
    @(posedge mclk) disable iff (!nrst) (take && !dataWr) |=> !txFull_reg;
  endproperty
  a_takeSetsEmpty: assert property (p_takeSetsEmpty) else $error("take kept full");

  property p_irqGate;
    @(posedge mclk) disable iff (!nrst)
    txIrq_reg |-> (!txFull_reg && $past(txIe));
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("irq without cause");

  property p_idleLoad;
    @(posedge mclk) disable iff (!nrst)
    (dataWr && enable && master && state_reg == ENG_IDLE && !txFull_reg)
      |-> ##2 !txFull_reg;
  endproperty
  a_idleLoad: assert property (p_idleLoad) else $error("idle load slow");

  property p_busySlaveHolds;
    @(posedge mclk) disable iff (!nrst)
    (!master && state_reg == ENG_SHIFT && txFull_reg) |=> txFull_reg;
  endproperty
  a_busySlaveHolds: assert property (p_busySlaveHolds) else $error("busy load");

  property p_faultGated;
    @(posedge mclk) disable iff (!nrst)
    (!faultEn_reg && !mode_fault_flag_reg) |=> !mode_fault_flag_reg;
  endproperty
  a_faultGated: assert property (p_faultGated) else $error("fault while off");

  property p_rxCapture;
    @(posedge mclk) disable iff (!nrst)
    (rxDone_reg && !rxFull_reg) |=> (rxFull_reg && rxBuf_reg == $past(shift_reg));
  endproperty
  a_rxCapture: assert property (p_rxCapture) else $error("rx not stored");

  property p_overrunKeeps;
    @(posedge mclk) disable iff (!nrst)
    (rxDone_reg && rxFull_reg) |=> (ovr_reg && $stable(rxBuf_reg));
  endproperty
  a_overrunKeeps: assert property (p_overrunKeeps) else $error("overrun lost");

  property p_readData;
    @(posedge mclk) disable iff (!nrst)
    (issue && !wbWeI && hit(wbAdrI, DATA_OFFS))
      |=> (wbAckO && wbDatO == 32'($past(rxBuf_reg)));
  endproperty
  a_readData: assert property (p_readData) else $error("bad data read");

  property p_faultClear;
    @(posedge mclk) disable iff (!nrst)
    (dataWr && modfArm_reg && !faultEvt) |=> !mode_fault_flag_reg;
  endproperty
  a_faultClear: assert property (p_faultClear) else $error("fault not cleared");

endmodule

// File: tb/ssd_spi_peer.sv
`timescale 1ns/1ps
// Far-side SPI slave, mode 0, MSB first; sends txByte, txByte+1, ...
module ssd_spi_peer (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] shReg;
  logic [7:0] nextTx;
  int bitCnt;
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
    shReg = 8'h00;
    nextTx = 8'h00;
    bitCnt = 0;
  end
  always @(negedge selN) begin
    shReg = txByte;
    nextTx = txByte + 8'h01;
    bitCnt = 0;
    miso = txByte[7];
  end
  // Released line must not keep its last level
  always @(posedge selN) begin
    miso = ~miso;
  end
  always @(posedge sclk) begin
    if (!selN) begin
      rxByte = {rxByte[6:0], mosi};
      bitCnt++;
    end
  end
  always @(negedge sclk) begin
    if (!selN) begin
      if (bitCnt == 8) begin
        shReg = nextTx;
        nextTx++;
        bitCnt = 0;
      end else begin
        shReg = shReg << 1;
      end
      miso = shReg[7];
    end
  end
endmodule

// File: tb/tb_ssd_spi_core.sv
`timescale 1ns/1ps
module tb_ssd_spi_core
  import ssd_pkg::*;
;
  logic mclk, nrst, wbCycI, wbStbI, wbWeI, wbAckO, selectN, txIrq;
  logic [7:0] wbAdrI;
  logic [31:0] wbDatI, wbDatO, rdVal;
  logic [3:0] wbSelI;
  logic sclkO, sclkOe, mosiO, mosiOe, misoO, misoOe, ssGpioMode;
  logic peerSelN, peerMiso, sclkW, mosiW, misoW, sSclk, sMosi;
  logic [7:0] peerTx, peerRx, tv, sOut;
  logic [7:0] bdTab [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
  int miscompares, totalChecks, cycleCount, n, half;

  ////////////////////////////////////////////////////////////////////////
  assign sclkW = sclkOe ? sclkO : sSclk;
  assign mosiW = mosiOe ? mosiO : sMosi;
  assign misoW = misoOe ? misoO : peerMiso;

  // Bench drives clock and data when the core is a slave
  ssd_spi_core dut (.mclk(mclk), .nrst(nrst), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbDatI(wbDatI),
    .wbSelI(wbSelI), .wbDatO(wbDatO), .wbAckO(wbAckO), .sclkI(sclkW),
    .sclkO(sclkO), .sclkOe(sclkOe), .mosiI(mosiW), .mosiO(mosiO),
    .mosiOe(mosiOe), .misoI(misoW), .misoO(misoO), .misoOe(misoOe),
    .selectN(selectN), .txIrq(txIrq), .ssGpioMode(ssGpioMode));

  ssd_spi_peer peer (.sclk(sclkW), .mosi(mosiW), .selN(peerSelN),
    .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));

  ////////////////////////////////////////////////////////////////////////
  always #20 mclk = ~mclk;

  task automatic close_out;
    if (miscompares == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycleCount++;
    if (cycleCount == 40000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until ack is sampled high, then releases it
  task automatic wb_io(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    int k;
    @(posedge mclk);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= w;
    wbAdrI <= a;
    wbDatI <= d;
    wbSelI <= 4'hF;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wbAckO !== 1'b1 && k < 50);
    rdVal = wbDatO;
    chk("ack", 32'h1, {31'h0, wbAckO});
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_io(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb_io(1'b0, a, 32'h0);
  endtask

  task automatic clk(input int c);
    repeat (c) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Data register only ever written or read whole, never merged
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'h00;
    wbDatI = 32'h0;
    wbSelI = 4'h0;
    selectN = 1'b1;
    peerSelN = 1'b1;
    peerTx = 8'h00;
    sSclk = 1'b0;
    sMosi = 1'b1;
    sOut = 8'h69;
    miscompares = 0;
    totalChecks = 0;
    cycleCount = 0;
    clk(8);
    nrst <= 1'b1;
    rd(CTRL_OFFS);
    chk("ctrl", 32'h10, rdVal);
    rd(STAT_OFFS);
    chk("status", 32'h08, rdVal);
    chk("txIrq", 32'h0, {31'h0, txIrq});
    wr(CTRL_OFFS, 32'hFF);
    rd(CTRL_OFFS);
    chk("ctrl", 32'h32, rdVal);
    wr(8'h0C, 32'hFF);
    rd(8'h0C);
    chk("unmapped", 32'h0, rdVal);
    clk(3);
    chk("txIrq", 32'h1, {31'h0, txIrq});
    chk("gpio", 32'h1, {31'h0, ssGpioMode});
    for (int r = 0; r < 4; r++) begin
      wr(STAT_OFFS, r);
      rd(STAT_OFFS);
      chk("rate", 32'h08 | r, rdVal);
      peerTx <= 8'hA5 ^ r[7:0];
      peerSelN <= 1'b0;
      tv = 8'h3C + r[7:0];
      clk(2);
      wr(DATA_OFFS, {24'h0, tv});
      clk(1);
      chk("txIrq", 32'h0, {31'h0, txIrq});
      clk(1);
      chk("txIrq", 32'h1, {31'h0, txIrq});
      n = 0;
      while (sclkO !== 1'b0 && n < 400) begin clk(1); n++; end
      while (sclkO !== 1'b1 && n < 400) begin clk(1); n++; end
      half = 0;
      while (sclkO === 1'b1 && half < 400) begin clk(1); half++; end
      chk("halfPeriod", {24'h0, bdTab[r]}, half);
      n = 0;
      do begin rd(STAT_OFFS); n++; end
        while (rdVal[STAT_RXF_BIT] !== 1'b1 && n < 1000);
      rd(DATA_OFFS);
      chk("rxData", {24'h0, peerTx}, rdVal);
      chk("peerRx", {24'h0, tv}, {24'h0, peerRx});
      rd(STAT_OFFS);
      chk("status", 32'h08 | r, rdVal);
      peerSelN <= 1'b1;
    end
    // Two bytes queued; second completes with receive still full
    wr(STAT_OFFS, 32'h0);
    peerTx <= 8'hC3;
    peerSelN <= 1'b0;
    clk(2);
    wr(DATA_OFFS, 32'h11);
    clk(1);
    n = 0;
    while (txIrq !== 1'b1 && n < 20) begin clk(1); n++; end
    wr(DATA_OFFS, 32'h22);
    rd(STAT_OFFS);
    chk("txEmpty", 32'h0, {31'h0, rdVal[STAT_TXE_BIT]});
    n = 0;
    do begin rd(STAT_OFFS); n++; end
      while (rdVal[STAT_OVR_BIT] !== 1'b1 && n < 200);
    rd(DATA_OFFS);
    chk("rxData", 32'hC3, rdVal);
    chk("peerRx", 32'h22, {24'h0, peerRx});
    rd(STAT_OFFS);
    chk("status", 32'h08, rdVal);
    peerSelN <= 1'b1;
    // Select low in master: fault only once detection is enabled
    selectN <= 1'b0;
    clk(6);
    rd(STAT_OFFS);
    chk("fault", 32'h0, {31'h0, rdVal[STAT_MODE_FAULT_FLAG_BIT]});
    wr(STAT_OFFS, 32'h04);
    clk(6);
    rd(STAT_OFFS);
    chk("fault", 32'h1, {31'h0, rdVal[STAT_MODE_FAULT_FLAG_BIT]});
    chk("gpio", 32'h0, {31'h0, ssGpioMode});
    wr(STAT_OFFS, 32'h0);
    selectN <= 1'b1;
    clk(6);
    rd(STAT_OFFS);
    chk("fault", 32'h1, {31'h0, rdVal[STAT_MODE_FAULT_FLAG_BIT]});
    wr(DATA_OFFS, 32'h5A);
    rd(STAT_OFFS);
    chk("fault", 32'h0, {31'h0, rdVal[STAT_MODE_FAULT_FLAG_BIT]});
    clk(60);
    wr(CTRL_OFFS, 32'h02);
    clk(4);
    chk("gpio", 32'h0, {31'h0, ssGpioMode});
    chk("sclkOe", 32'h0, {31'h0, sclkOe});
    // Slave: preload, then a write mid-transfer waits for the end
    rd(DATA_OFFS);
    wr(DATA_OFFS, 32'h96);
    selectN <= 1'b0;
    clk(4);
    wr(DATA_OFFS, 32'h5C);
    rd(STAT_OFFS);
    chk("txEmpty", 32'h0, {31'h0, rdVal[STAT_TXE_BIT]});
    for (int i = 7; i >= 0; i--) begin
      sMosi <= sOut[i];
      clk(4);
      tv = {tv[6:0], misoW};
      sSclk <= 1'b1;
      clk(4);
      sSclk <= 1'b0;
    end
    clk(4);
    rd(STAT_OFFS);
    chk("status", 32'h88, rdVal);
    rd(DATA_OFFS);
    chk("rxData", {24'h0, sOut}, rdVal);
    chk("slaveMiso", 32'h96, {24'h0, tv});
    selectN <= 1'b1;
    wr(CTRL_OFFS, 32'h00);
    clk(4);
    chk("gpio", 32'h1, {31'h0, ssGpioMode});
    close_out;
  end
endmodule
